//--- rtl/bsf_pkg.sv
// constants, opcodes and register map of the bit, shift and flag unit
//
// How it works
// - io bit set forces the chosen io bit high, flags kept, two cycles
// - io bit clear forces the chosen io bit low, flags kept, two cycles
// - left shift moves bits up, zero into bit 0, sets Z C N V
// - right shift moves bits down, zero into bit 7, sets Z C N V
// - left rotate puts old carry in bit 0, old bit 7 in carry
// - right rotate puts old carry in bit 7, old bit 0 in carry
// - arithmetic right shift keeps bit 7, sets Z C N V, one cycle
// - nibble exchange swaps halves, flags untouched, one cycle
// - status bit assert or deassert touches only the selected bit
// - register bit copied into transfer flag, nothing else changes
// - transfer flag copied into register bit, flags untouched
// - carry set or clear alters only carry, one cycle
// - negative or zero set or clear alters only that flag
// - sign set or clear alters only the sign flag
// - overflow set or clear alters only the overflow flag
package bsf_pkg;

    // ---------------------------------------------------------------
    // register map, word addresses
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W         = 8;
    localparam logic [7:0]  ADDR_CMD       = 8'h00;
    localparam logic [7:0]  ADDR_OPERAND   = 8'h01;
    localparam logic [7:0]  ADDR_STATUS    = 8'h02;
    localparam logic [7:0]  ADDR_SELECT    = 8'h03;
    localparam logic [7:0]  ADDR_GPR_DATA  = 8'h04;
    localparam logic [7:0]  ADDR_IO_DATA   = 8'h05;
    localparam int unsigned CMD_BUSY_BIT   = 7;

    // ---------------------------------------------------------------
    // field layout, storage sizes, reset values, cycle counts
    // ---------------------------------------------------------------
    localparam int unsigned IDX_W          = 5;
    localparam int unsigned IDX_LSB        = 0;
    localparam int unsigned BITSEL_LSB     = 5;
    localparam int unsigned STORE_DEPTH    = 32;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [7:0]  DATA_RESET     = 8'h00;
    localparam int unsigned IO_OP_CYCLES   = 2;
    localparam int unsigned ONE_OP_CYCLES  = 1;

    // status bit positions
    localparam logic [2:0]  FLAG_C         = 3'h0;
    localparam logic [2:0]  FLAG_Z         = 3'h1;
    localparam logic [2:0]  FLAG_N         = 3'h2;
    localparam logic [2:0]  FLAG_V         = 3'h3;
    localparam logic [2:0]  FLAG_S         = 3'h4;
    localparam logic [2:0]  FLAG_T         = 3'h6;

    typedef enum logic [4:0] {
        OP_NONE                 = 5'h00,
        OP_IO_BIT_SET           = 5'h01,
        OP_IO_BIT_CLEAR         = 5'h02,
        OP_LOGICAL_LEFT_SHIFT   = 5'h03,
        OP_LOGICAL_RIGHT_SHIFT  = 5'h04,
        OP_LEFT_ROTATE_CARRY    = 5'h05,
        OP_RIGHT_ROTATE_CARRY   = 5'h06,
        OP_ARITH_RIGHT_SHIFT    = 5'h07,
        OP_NIBBLE_EXCHANGE      = 5'h08,
        OP_STATUS_BIT_ASSERT    = 5'h09,
        OP_STATUS_BIT_DEASSERT  = 5'h0A,
        OP_REG_BIT_TO_TRANSFER  = 5'h0B,
        OP_TRANSFER_TO_REG_BIT  = 5'h0C,
        OP_CARRY_ASSERT         = 5'h0D,
        OP_CARRY_DEASSERT       = 5'h0E,
        OP_NEGATIVE_ASSERT      = 5'h0F,
        OP_NEGATIVE_DEASSERT    = 5'h10,
        OP_ZERO_ASSERT          = 5'h11,
        OP_ZERO_DEASSERT        = 5'h12,
        OP_SIGN_ASSERT          = 5'h13,
        OP_SIGN_DEASSERT        = 5'h14,
        OP_OVERFLOW_ASSERT      = 5'h15,
        OP_OVERFLOW_DEASSERT    = 5'h16
    } bsf_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_IOWB  = 3'b100
    } bsf_state_t;

endpackage : bsf_pkg

//--- rtl/bsf_unit.sv
// bit manipulation, shift and status flag datapath with register port
//
// The strobed register port and the address map were chosen for this implementation.
module bsf_unit (
    input  wire logic                       core_clk,
    input  wire logic                       reset,
    input  wire logic                       clkEn,
    input  wire logic [bsf_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                 wrData,
    input  wire logic                       wrEn,
    input  wire logic                       rdEn,
    output logic      [7:0]                 rdData,
    output logic      [7:0]                 statusFlags,
    output logic                            busy,
    output logic                            opDone
);
    import bsf_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0]       gprFile [STORE_DEPTH];
    logic [7:0]       ioFile  [STORE_DEPTH];
    logic [7:0]       statusReg;
    logic [7:0]       rdDataReg;
    logic             doneReg;
    logic             busyReg;
    logic [IDX_W-1:0] selectReg;
    logic [7:0]       operandReg;
    logic [IDX_W-1:0] idxReg;
    logic [2:0]       bitReg;
    bsf_op_t          opReg;
    bsf_state_t       stateReg;
    logic [7:0]       ioTempReg;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // returns {carry out, result}
    function automatic logic [8:0] shift_calc(input bsf_op_t op,
                                              input logic [7:0] v,
                                              input logic c);
        logic [8:0] r;
        r = {c, v};
        unique case (op)
            OP_LOGICAL_LEFT_SHIFT:  r = {v[7], v[6:0], 1'b0};
            OP_LOGICAL_RIGHT_SHIFT: r = {v[0], 1'b0, v[7:1]};
            OP_LEFT_ROTATE_CARRY:   r = {v[7], v[6:0], c};
            OP_RIGHT_ROTATE_CARRY:  r = {v[0], c, v[7:1]};
            OP_ARITH_RIGHT_SHIFT:   r = {v[0], v[7], v[7:1]};
            default:                r = {c, v};
        endcase
        return r;
    endfunction : shift_calc
    function automatic logic is_shift(input bsf_op_t op);
        return op inside {OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
                          OP_LEFT_ROTATE_CARRY, OP_RIGHT_ROTATE_CARRY,
                          OP_ARITH_RIGHT_SHIFT};
    endfunction : is_shift
    // returns {hit, position, value} for single status bit writes
    function automatic logic [4:0] flag_write(input bsf_op_t op,
                                              input logic [2:0] sel);
        logic [4:0] f;
        f = 5'h00;
        unique case (op)
            OP_STATUS_BIT_ASSERT:   f = {1'b1, sel, 1'b1};
            OP_STATUS_BIT_DEASSERT: f = {1'b1, sel, 1'b0};
            OP_CARRY_ASSERT:        f = {1'b1, FLAG_C, 1'b1};
            OP_CARRY_DEASSERT:      f = {1'b1, FLAG_C, 1'b0};
            OP_NEGATIVE_ASSERT:     f = {1'b1, FLAG_N, 1'b1};
            OP_NEGATIVE_DEASSERT:   f = {1'b1, FLAG_N, 1'b0};
            OP_ZERO_ASSERT:         f = {1'b1, FLAG_Z, 1'b1};
            OP_ZERO_DEASSERT:       f = {1'b1, FLAG_Z, 1'b0};
            OP_SIGN_ASSERT:         f = {1'b1, FLAG_S, 1'b1};
            OP_SIGN_DEASSERT:       f = {1'b1, FLAG_S, 1'b0};
            OP_OVERFLOW_ASSERT:     f = {1'b1, FLAG_V, 1'b1};
            OP_OVERFLOW_DEASSERT:   f = {1'b1, FLAG_V, 1'b0};
            default:                f = 5'h00;
        endcase
        return f;
    endfunction : flag_write
    // ---------------------------------------------------------------
    // decode and datapath
    // ---------------------------------------------------------------
    logic       idle;
    logic       execNow;
    logic       cmdTake;
    logic       busWrite;
    logic [7:0] srcVal;
    logic [8:0] shiftOut;
    logic [4:0] flagOut;
    logic [7:0] gprBitWr;
    assign idle     = (stateReg == ST_IDLE);
    assign execNow  = clkEn && (stateReg == ST_EXEC);
    assign cmdTake  = clkEn && wrEn && idle && (addr == ADDR_CMD);
    // data writes while busy are dropped so an operation sees stable state
    assign busWrite = clkEn && wrEn && idle;
    assign srcVal   = gprFile[idxReg];
    assign shiftOut = shift_calc(opReg, srcVal, statusReg[FLAG_C]);
    assign flagOut  = flag_write(opReg, bitReg);
    always_comb begin
        gprBitWr = srcVal;
        gprBitWr[bitReg] = statusReg[FLAG_T];
    end

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stateReg <= ST_IDLE;
            opReg    <= OP_NONE;
            idxReg   <= '0;
            bitReg   <= 3'h0;
            doneReg  <= 1'b0;
            busyReg  <= 1'b0;
        end else if (clkEn) begin
            doneReg <= 1'b0;
            busyReg <= 1'b0;
            unique case (stateReg)
                ST_IDLE: begin
                    if (cmdTake) begin
                        busyReg  <= 1'b1;
                        opReg    <= bsf_op_t'(wrData[4:0]);
                        idxReg   <= operandReg[IDX_LSB +: IDX_W];
                        bitReg   <= operandReg[BITSEL_LSB +: 3];
                        stateReg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    // io ops take a second cycle for write back
                    if (opReg == OP_IO_BIT_SET ||
                        opReg == OP_IO_BIT_CLEAR) begin
                        stateReg <= ST_IOWB;
                        busyReg  <= 1'b1;
                    end else begin
                        stateReg <= ST_IDLE;
                        doneReg  <= 1'b1;
                    end
                end
                ST_IOWB: begin
                    stateReg <= ST_IDLE;
                    doneReg  <= 1'b1;
                end
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // io register file
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ioTempReg <= DATA_RESET;
            for (int i = 0; i < STORE_DEPTH; i++) begin
                ioFile[i] <= DATA_RESET;
            end
        end else if (clkEn) begin
            if (stateReg == ST_EXEC) begin
                ioTempReg <= ioFile[idxReg];
                ioTempReg[bitReg] <= (opReg == OP_IO_BIT_SET);
            end
            if (stateReg == ST_IOWB) begin
                ioFile[idxReg] <= ioTempReg;
            end else if (busWrite && addr == ADDR_IO_DATA) begin
                ioFile[selectReg] <= wrData;
            end
        end
    end

    // ---------------------------------------------------------------
    // general register file
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < STORE_DEPTH; i++) begin
                gprFile[i] <= DATA_RESET;
            end
        end else if (clkEn) begin
            if (execNow && is_shift(opReg)) begin
                gprFile[idxReg] <= shiftOut[7:0];
            end else if (execNow && opReg == OP_NIBBLE_EXCHANGE) begin
                gprFile[idxReg] <= {srcVal[3:0], srcVal[7:4]};
            end else if (execNow && opReg == OP_TRANSFER_TO_REG_BIT) begin
                gprFile[idxReg] <= gprBitWr;
            end else if (busWrite && addr == ADDR_GPR_DATA) begin
                gprFile[selectReg] <= wrData;
            end
        end
    end

    // ---------------------------------------------------------------
    // status register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            statusReg <= STATUS_RESET;
        end else if (clkEn) begin
            if (execNow && is_shift(opReg)) begin
                // sign flag is not among the flags a shift updates
                statusReg[FLAG_C] <= shiftOut[8];
                statusReg[FLAG_Z] <= (shiftOut[7:0] == 8'h00);
                statusReg[FLAG_N] <= shiftOut[7];
                statusReg[FLAG_V] <= shiftOut[7] ^ shiftOut[8];
            end else if (execNow && flagOut[4]) begin
                statusReg[flagOut[3:1]] <= flagOut[0];
            end else if (execNow && opReg == OP_REG_BIT_TO_TRANSFER) begin
                statusReg[FLAG_T] <= srcVal[bitReg];
            end else if (busWrite && addr == ADDR_STATUS) begin
                statusReg <= wrData;
            end
        end
    end

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            operandReg <= DATA_RESET;
            selectReg  <= '0;
        end else if (busWrite) begin
            if (addr == ADDR_OPERAND) begin
                operandReg <= wrData;
            end
            if (addr == ADDR_SELECT) begin
                selectReg <= wrData[IDX_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdDataReg <= DATA_RESET;
        end else if (clkEn) begin
            rdDataReg <= 8'h00;
            if (rdEn) begin
                unique case (addr)
                    ADDR_CMD:      rdDataReg <= {~idle, 2'b00, opReg};
                    ADDR_OPERAND:  rdDataReg <= operandReg;
                    ADDR_STATUS:   rdDataReg <= statusReg;
                    ADDR_SELECT:   rdDataReg <= {3'h0, selectReg};
                    ADDR_GPR_DATA: rdDataReg <= gprFile[selectReg];
                    ADDR_IO_DATA:  rdDataReg <= ioFile[selectReg];
                    default:       rdDataReg <= 8'h00;
                endcase
            end
        end
    end
    assign rdData      = rdDataReg;
    assign statusFlags = statusReg;
    assign busy        = busyReg;
    assign opDone      = doneReg;
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_exec(bsf_op_t op);
        execNow && opReg == op;
    endsequence
    sequence s_io_writeback;
        clkEn && stateReg == ST_IOWB;
    endsequence
    property p_io_set;
        s_exec(OP_IO_BIT_SET) ##1 s_io_writeback |=>
            ioFile[idxReg][bitReg] && opDone
            && statusReg == $past(statusReg, 2);
    endproperty
    a_io_set: assert property (p_io_set)
        else $error("io bit set result or timing wrong");
    property p_io_clear;
        s_exec(OP_IO_BIT_CLEAR) |=> !opDone ##1
            (!ioFile[idxReg][bitReg] && opDone && idle);
    endproperty
    a_io_clear: assert property (p_io_clear)
        else $error("io bit clear result or timing wrong");
    property p_left_shift;
        s_exec(OP_LOGICAL_LEFT_SHIFT) |=>
            gprFile[idxReg] == {$past(srcVal[6:0]), 1'b0}
            && statusReg[FLAG_V] == (statusReg[FLAG_N] ^ statusReg[FLAG_C]);
    endproperty
    a_left_shift: assert property (p_left_shift)
        else $error("left shift result wrong");
    property p_right_shift;
        s_exec(OP_LOGICAL_RIGHT_SHIFT) |=>
            gprFile[idxReg] == {1'b0, $past(srcVal[7:1])} && opDone;
    endproperty
    a_right_shift: assert property (p_right_shift)
        else $error("right shift result wrong");
    property p_left_rotate;
        s_exec(OP_LEFT_ROTATE_CARRY) |=>
            gprFile[idxReg] == {$past(srcVal[6:0]), $past(statusReg[0])}
            && statusReg[FLAG_C] == $past(srcVal[7]);
    endproperty
    a_left_rotate: assert property (p_left_rotate)
        else $error("left rotate result wrong");
    property p_right_rotate;
        s_exec(OP_RIGHT_ROTATE_CARRY) |=>
            gprFile[idxReg] == {$past(statusReg[0]), $past(srcVal[7:1])}
            && statusReg[FLAG_C] == $past(srcVal[0]);
    endproperty
    a_right_rotate: assert property (p_right_rotate)
        else $error("right rotate result wrong");
    property p_arith_shift;
        s_exec(OP_ARITH_RIGHT_SHIFT) |=>
            gprFile[idxReg] == {$past(srcVal[7]), $past(srcVal[7:1])}
            && statusReg[FLAG_S] == $past(statusReg[FLAG_S]);
    endproperty
    a_arith_shift: assert property (p_arith_shift)
        else $error("arithmetic shift result wrong");
    property p_nibble;
        s_exec(OP_NIBBLE_EXCHANGE) |=>
            gprFile[idxReg] == {$past(srcVal[3:0]), $past(srcVal[7:4])}
            && $stable(statusReg);
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("nibble exchange wrong or flags moved");
    property p_status_bit;
        s_exec(OP_STATUS_BIT_ASSERT) |=> statusReg[bitReg]
            && ((statusReg ^ $past(statusReg)) & ~(8'h01 << bitReg)) == 8'h00;
    endproperty
    a_status_bit: assert property (p_status_bit)
        else $error("status bit assert touched other bits");
    property p_to_transfer;
        s_exec(OP_REG_BIT_TO_TRANSFER) |=>
            statusReg[FLAG_T] == $past(srcVal[bitReg])
            && statusReg[5:0] == $past(statusReg[5:0]);
    endproperty
    a_to_transfer: assert property (p_to_transfer)
        else $error("transfer flag copy wrong");
    property p_from_transfer;
        s_exec(OP_TRANSFER_TO_REG_BIT) |=>
            gprFile[idxReg][bitReg] == statusReg[FLAG_T] && $stable(statusReg);
    endproperty
    a_from_transfer: assert property (p_from_transfer)
        else $error("register bit load wrong");
    property p_carry_set;
        s_exec(OP_CARRY_ASSERT) |=> statusReg[FLAG_C]
            && statusReg[7:1] == $past(statusReg[7:1]);
    endproperty
    a_carry_set: assert property (p_carry_set)
        else $error("carry set wrong");
    property p_zero_clear;
        s_exec(OP_ZERO_DEASSERT) |=> !statusReg[FLAG_Z]
            && statusReg[FLAG_N] == $past(statusReg[FLAG_N]);
    endproperty
    a_zero_clear: assert property (p_zero_clear)
        else $error("zero clear wrong");
    property p_sign_set;
        s_exec(OP_SIGN_ASSERT) |=> statusReg[FLAG_S]
            && statusReg[3:0] == $past(statusReg[3:0]);
    endproperty
    a_sign_set: assert property (p_sign_set)
        else $error("sign set wrong");
    property p_ovf_clear;
        s_exec(OP_OVERFLOW_DEASSERT) |=> !statusReg[FLAG_V]
            && statusReg[2:0] == $past(statusReg[2:0]);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow clear wrong");
    property p_shift_flags;
        execNow && is_shift(opReg) |=>
            statusReg[FLAG_Z] == (gprFile[idxReg] == 8'h00)
            && statusReg[FLAG_N] == gprFile[idxReg][7];
    endproperty
    a_shift_flags: assert property (p_shift_flags)
        else $error("shift flags wrong");

endmodule : bsf_unit

//--- verif/testbench.sv
// self-checking bench for the bit, shift and flag unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bsf_pkg::*;
    // ---------------------------------------------------------------
    // signals and instance
    // ---------------------------------------------------------------
    logic       core_clk, reset, clkEn, wrEn, rdEn, busy, opDone;
    logic [7:0] addr, wrData, rdData, statusFlags, v;
    int         nMismatch = 0;
    int         cmpCount  = 0;
    bsf_unit u_bsf_unit (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
        .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData(rdData), .statusFlags(statusFlags), .busy(busy),
        .opDone(opDone));
    // ---------------------------------------------------------------
    // bus and check tasks
    // ---------------------------------------------------------------
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        wrEn <= 1'b1; addr <= a; wrData <= d;
        @(posedge core_clk);
        wrEn <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        rdEn <= 1'b1; addr <= a;
        @(posedge core_clk);
        rdEn <= 1'b0;
        #1 d = rdData;
    endtask : rd
    task automatic put(logic [7:0] a, logic [4:0] i, logic [7:0] d);
        wr(ADDR_SELECT, {3'h0, i});
        wr(a, d);
    endtask : put
    // n counts enabled edges from the command edge to opDone
    task automatic run_op(logic [4:0] op, logic [7:0] opnd, int cyc);
        int n;
        n = 0;
        wr(ADDR_OPERAND, opnd);
        wr(ADDR_CMD, {3'h0, op});
        #1 chk("busy", {7'h0, busy}, 8'h01);
        while (opDone !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("cycles", n[7:0], cyc[7:0]);
        chk("idle", {7'h0, busy}, 8'h00);
    endtask : run_op
    function automatic logic [15:0] model(logic [4:0] op, logic [7:0] x,
                                          logic [7:0] s);
        logic [7:0] r;
        logic       c;
        c = x[0];
        r = {1'b0, x[7:1]};
        case (op)
            OP_LOGICAL_LEFT_SHIFT: begin r = {x[6:0], 1'b0}; c = x[7]; end
            OP_LEFT_ROTATE_CARRY:  begin r = {x[6:0], s[FLAG_C]}; c = x[7]; end
            OP_RIGHT_ROTATE_CARRY: r = {s[FLAG_C], x[7:1]};
            OP_ARITH_RIGHT_SHIFT:  r = {x[7], x[7:1]};
            OP_NIBBLE_EXCHANGE:    return {x[3:0], x[7:4], s};
            default: ;
        endcase
        s[FLAG_C] = c; s[FLAG_Z] = (r == 8'h00);
        s[FLAG_N] = r[7]; s[FLAG_V] = r[7] ^ c;
        return {r, s};
    endfunction : model
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_shift();
        logic [7:0]  vals [4] = '{8'h81, 8'h40, 8'h00, 8'h01};
        logic [7:0]  st;
        logic [15:0] e;
        for (int o = 3; o <= 8; o++) begin
            for (int k = 0; k < 8; k++) begin
                st = k[0] ? 8'hE1 : 8'h10;
                put(ADDR_GPR_DATA, 5'h09, vals[k/2]);
                wr(ADDR_STATUS, st);
                run_op(o[4:0], 8'h09, ONE_OP_CYCLES);
                e = model(o[4:0], vals[k/2], st);
                rd(ADDR_GPR_DATA, v);
                chk("result", v, e[15:8]);
                chk("flags", statusFlags, e[7:0]);
                chk("flagsr", statusFlags, e[7:0]);
            end
        end
    endtask : t_shift
    task automatic t_io();
        wr(ADDR_STATUS, 8'h5A);
        put(ADDR_IO_DATA, 5'h1F, 8'h00);
        run_op(OP_IO_BIT_SET, 8'hDF, IO_OP_CYCLES);
        rd(ADDR_IO_DATA, v);
        chk("io set", v, 8'h40);
        put(ADDR_IO_DATA, 5'h1F, 8'hFF);
        run_op(OP_IO_BIT_CLEAR, 8'h3F, IO_OP_CYCLES);
        rd(ADDR_IO_DATA, v);
        chk("io clr", v, 8'hFD);
        chk("io flags", statusFlags, 8'h5A);
    endtask : t_io
    task automatic t_flags();
        logic [2:0] fl [5] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_S, FLAG_V};
        logic [7:0] m;
        for (int i = 0; i < 26; i++) begin
            m = (i < 10) ? 8'h01 << fl[i/2] : 8'h01 << ((i - 10) / 2);
            wr(ADDR_STATUS, i[0] ? 8'hFF : 8'h00);
            if (i < 10)
                run_op(OP_CARRY_ASSERT + i[4:0], 8'h00, ONE_OP_CYCLES);
            else
                run_op(OP_STATUS_BIT_ASSERT + i[0], m == 8'h01 ? 8'h00 :
                       {3'((i - 10) / 2), 5'h00}, ONE_OP_CYCLES);
            chk("flag op", statusFlags, i[0] ? ~m : m);
            chk("flag op2", statusFlags, i[0] ? ~m : m);
            chk("flag op3", statusFlags, i[0] ? ~m : m);
        end
    endtask : t_flags
    task automatic t_transfer();
        put(ADDR_GPR_DATA, 5'h03, 8'h10);
        wr(ADDR_STATUS, 8'h00);
        run_op(OP_REG_BIT_TO_TRANSFER, 8'h83, ONE_OP_CYCLES);
        chk("t set", statusFlags, 8'h40);
        put(ADDR_GPR_DATA, 5'h05, 8'h00);
        run_op(OP_TRANSFER_TO_REG_BIT, 8'h45, ONE_OP_CYCLES);
        rd(ADDR_GPR_DATA, v);
        chk("t load", v, 8'h04);
        chk("t flags", statusFlags, 8'h40);
        wr(ADDR_STATUS, 8'hFF);
        run_op(OP_REG_BIT_TO_TRANSFER, 8'h03, ONE_OP_CYCLES);
        chk("t clr", statusFlags, 8'hBF);
    endtask : t_transfer
    // status write right behind the command must be refused while busy
    task automatic t_refuse();
        wr(ADDR_STATUS, 8'h00);
        @(posedge core_clk);
        wrEn <= 1'b1; addr <= ADDR_CMD; wrData <= {3'h0, OP_NIBBLE_EXCHANGE};
        @(posedge core_clk);
        addr <= ADDR_STATUS; wrData <= 8'hFF;
        @(posedge core_clk);
        wrEn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("refused", statusFlags, 8'h00);
        rd(8'h3F, v);
        chk("unmapped", v, 8'h00);
        wr(ADDR_OPERAND, 8'h00);
        wr(ADDR_CMD, {3'h0, OP_CARRY_ASSERT});
        clkEn <= 1'b0;
        repeat (3) @(posedge core_clk);
        clkEn <= 1'b1;
        #1 chk("frozen", {7'h0, opDone}, 8'h00);
        chk("held", {7'h0, busy}, 8'h01);
        @(posedge core_clk);
        #1 chk("thawed", statusFlags, 8'h01);
        rd(ADDR_CMD, v);
        chk("cmd read", v, {3'h0, OP_CARRY_ASSERT});
    endtask : t_refuse
    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic stop_test();
        if (nMismatch == 0 && cmpCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #400000;
        nMismatch++;
        stop_test();
    end
    initial begin
        reset = 1'b1; clkEn = 1'b1; wrEn = 1'b0; rdEn = 1'b0;
        addr = 8'h00; wrData = 8'h00;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_STATUS, v);
        chk("reset status", v, STATUS_RESET);
        t_shift();
        t_io();
        t_flags();
        t_transfer();
        t_refuse();
        stop_test();
    end
endmodule : testbench
